//--- logic/scid_pkg.sv
// constants, register map and carrier types of the servo command input decoder
package scid_pkg;
  localparam int CLK_PERIOD_NS  = 100;
  // shortest pulse spacing at the rated maximum of each path, in ns
  localparam int LR_PERIOD_NS   = 250;
  localparam int PC_PERIOD_NS   = 2000;
  localparam int OC_PERIOD_NS   = 5000;
  localparam logic [7:0] LR_MIN_CYC = 8'(LR_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [7:0] PC_MIN_CYC = 8'(PC_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [7:0] OC_MIN_CYC = 8'(OC_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [3:0] BURST_GAP_CYC  = 4'h4;
  localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

  localparam int N_TERM = 10;
  localparam int SYNC_W = 16;

  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_SPD_SCALE = 8'h04;
  localparam logic [7:0] ADDR_TRQ_SCALE = 8'h08;
  localparam logic [7:0] ADDR_TLM_SCALE = 8'h0C;
  localparam logic [7:0] ADDR_ASSIGN_LO = 8'h10;
  localparam logic [7:0] ADDR_ASSIGN_HI = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_POSITION  = 8'h1C;

  localparam int STAT_ALARM_BIT = 3;
  localparam int STAT_RATE_BIT  = 4;

  localparam logic [31:0] RST_CONFIG    = 32'h0000_0000;
  localparam logic [15:0] RST_SCALE     = 16'h0100;
  // terminal 0 reverse overtravel, terminal 1 forward overtravel, terminal 5 run
  localparam logic [29:0] RST_ASSIGN_LO = 30'h0200_0043;
  localparam logic [19:0] RST_ASSIGN_HI = 20'h0_0000;

  localparam logic [3:0] FN_NONE   = 4'h0;
  localparam logic [3:0] FN_RUN    = 4'h1;
  localparam logic [3:0] FN_FWD_OT = 4'h2;
  localparam logic [3:0] FN_REV_OT = 4'h3;

  localparam logic [1:0] MODE_POS    = 2'h0;
  localparam logic [1:0] MODE_SPEED  = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;

  typedef enum logic [1:0] {
    ABS_IDLE   = 2'b00,
    ABS_SERIAL = 2'b01,
    ABS_BURST  = 2'b10,
    ABS_DONE   = 2'b11
  } scid_abs_e;

  typedef struct packed {
    logic       open_collector;
    logic [2:0] torque_limit_select;
    logic [1:0] torque_cmd_speed_limit_select;
    logic [1:0] overtravel_stop_select;
    logic [1:0] drive_prohibit_select;
    logic       absolute_iface_select;
    logic [1:0] pulse_mode_select;
    logic       pulse_direction_invert;
    logic       pulse_path_select;
  } scid_cfg_s;

  typedef struct packed {
    logic              speed_cmd_valid;
    logic              torque_cmd_valid;
    logic              speed_limit_valid;
    logic              fwd_limit_valid;
    logic              rev_limit_valid;
    logic signed [15:0] speed_cmd;
    logic signed [15:0] torque_cmd;
    logic signed [15:0] speed_limit;
    logic signed [15:0] fwd_limit;
    logic signed [15:0] rev_limit;
  } scid_analog_s;
endpackage : scid_pkg

//--- logic/scid_sync.sv
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module scid_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : scid_sync

//--- logic/scid_top.sv
// servo command input decoder: pulse decode, sequence inputs, absolute start-up and analog routing
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
module scid_top (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  lr_phase_a,
  input  wire logic                  lr_phase_b,
  input  wire logic                  pc_led_a,
  input  wire logic                  pc_led_b,
  input  wire logic [9:0]            seq_terminal,
  input  wire logic                  sensor_on_input,
  input  wire logic                  encoder_connected,
  input  wire logic                  encoder_ready,
  input  wire logic                  abs_serial_done,
  input  wire logic [15:0]           single_turn_pos,
  input  wire logic [1:0]            control_mode,
  input  wire logic signed [11:0]    analog_in1,
  input  wire logic signed [11:0]    analog_in2,
  input  wire logic signed [11:0]    analog_in3,
  output logic                       cmd_step,
  output logic                       cmd_forward,
  output logic                       drive_enable,
  output logic                       abs_serial_start,
  output logic                       abs_inc_pulse,
  output logic                       fwd_stop_request,
  output logic                       rev_stop_request,
  output logic      [1:0]            stop_action,
  output logic                       overtravel_protection_alarm,
  output scid_pkg::scid_analog_s     analog_route
);
  scid_pkg::scid_cfg_s    cfg;
  logic [15:0]            speed_cmd_scale;
  logic [15:0]            torque_cmd_scale;
  logic [15:0]            analog_torque_limit_scale;
  logic [29:0]            assign_lo;
  logic [19:0]            assign_hi;
  logic                   rate_error;
  logic [31:0]            position;
  logic [7:0]             gap_cnt;
  logic                   prev_a;
  logic                   prev_b;
  logic                   enc_present;
  logic                   enc_captured;
  logic [1:0]             strap_cnt;
  logic                   sensor_ok_d;
  scid_pkg::scid_abs_e    abs_state;
  scid_pkg::scid_abs_e    next_abs_state;
  logic [15:0]            burst_left;
  logic [3:0]             burst_gap;

  // synchronised pin images
  logic [15:0]            pins_raw;
  logic [15:0]            pins_s;
  assign pins_raw = {sensor_on_input, encoder_connected, lr_phase_a, lr_phase_b,
                     pc_led_a, pc_led_b, seq_terminal};

  scid_sync #(.W(scid_pkg::SYNC_W)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  wire       sen_s   = pins_s[15];
  wire       encc_s  = pins_s[14];
  // photocoupler level is high while the LED conducts
  wire       a_sel   = cfg.pulse_path_select ? pins_s[13] : pins_s[11];
  wire       b_sel   = cfg.pulse_path_select ? pins_s[12] : pins_s[10];
  wire [9:0] term_s  = pins_s[9:0];

  // pulse decode
  wire [3:0] quad_tr = {prev_a, prev_b, a_sel, b_sel};
  wire       quad_f  = (quad_tr == 4'h2) || (quad_tr == 4'hB) || (quad_tr == 4'hD) || (quad_tr == 4'h4);
  wire       quad_r  = (quad_tr == 4'h1) || (quad_tr == 4'h7) || (quad_tr == 4'hE) || (quad_tr == 4'h8);
  wire       rise_a  = a_sel && !prev_a;
  wire       rise_b  = b_sel && !prev_b;
  logic      raw_step;
  logic      raw_fwd;
  always_comb begin
    raw_step = 1'b0;
    raw_fwd  = 1'b0;
    case (cfg.pulse_mode_select)
      2'h1: begin
        raw_step = rise_a ^ rise_b;
        raw_fwd  = rise_b;
      end
      2'h3: begin
        raw_step = rise_a;
        raw_fwd  = b_sel;
      end
      default: begin
        raw_step = quad_f || quad_r;
        raw_fwd  = quad_f;
      end
    endcase
  end

  wire       dir_fwd  = raw_fwd ^ cfg.pulse_direction_invert;
  wire [7:0] min_gap  = cfg.pulse_path_select ? scid_pkg::LR_MIN_CYC :
                        (cfg.open_collector ? scid_pkg::OC_MIN_CYC : scid_pkg::PC_MIN_CYC);
  // quadrature edges come four per pulse, so spacing is checked on pulse lines only
  wire       pulse_md = cfg.pulse_mode_select[0];
  // no decoding until the synchroniser and previous-level flops hold real pin levels after reset
  wire       step_ok  = raw_step && enc_captured;
  wire       too_fast = step_ok && pulse_md && (gap_cnt < min_gap);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_a      <= 1'b0;
      prev_b      <= 1'b0;
      cmd_step    <= 1'b0;
      cmd_forward <= 1'b0;
      gap_cnt     <= 8'hFF;
      position    <= 32'h0000_0000;
    end else if (clk_en) begin
      prev_a      <= a_sel;
      prev_b      <= b_sel;
      cmd_step    <= step_ok;
      cmd_forward <= dir_fwd;
      if (step_ok) begin
        gap_cnt  <= 8'h01;
        position <= dir_fwd ? position + 32'h0000_0001 : position - 32'h0000_0001;
      end else if (gap_cnt != 8'hFF) begin
        gap_cnt <= gap_cnt + 8'h01;
      end
    end
  end

  // sequence terminal function resolution
  wire [49:0] assign_all = {assign_hi, assign_lo};
  logic [9:0] t_run;
  logic [9:0] t_fot;
  logic [9:0] t_rot;
  logic [9:0] t_is_run;
  genvar gi;
  generate
    for (gi = 0; gi < scid_pkg::N_TERM; gi++) begin : g_term
      wire [3:0] fn  = assign_all[5*gi +: 4];
      wire       lvl = term_s[gi] ^ assign_all[5*gi + 4];
      assign t_is_run[gi] = (fn == scid_pkg::FN_RUN);
      assign t_run[gi]    = t_is_run[gi] && lvl;
      assign t_fot[gi]    = (fn == scid_pkg::FN_FWD_OT) && lvl;
      assign t_rot[gi]    = (fn == scid_pkg::FN_REV_OT) && lvl;
    end
  endgenerate

  wire run_assigned = |t_is_run;
  wire run_active   = |t_run;
  wire fwd_ot       = |t_fot;
  wire rev_ot       = |t_rot;

  // encoder presence is caught once, shortly after reset release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap_cnt    <= 2'h0;
      enc_captured <= 1'b0;
      enc_present  <= 1'b0;
    end else if (clk_en && !enc_captured) begin
      if (strap_cnt == scid_pkg::STRAP_WAIT_CYC) begin
        enc_captured <= 1'b1;
        enc_present  <= encc_s;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  wire sensor_ok = cfg.absolute_iface_select && enc_captured && enc_present && sen_s;

  // absolute start-up sequence
  always_comb begin
    next_abs_state = abs_state;
    case (abs_state)
      scid_pkg::ABS_IDLE:   if (sensor_ok && !sensor_ok_d) next_abs_state = scid_pkg::ABS_SERIAL;
      scid_pkg::ABS_SERIAL: if (abs_serial_done) next_abs_state = scid_pkg::ABS_BURST;
      scid_pkg::ABS_BURST:  if (burst_left == 16'h0000) next_abs_state = scid_pkg::ABS_DONE;
      scid_pkg::ABS_DONE:   next_abs_state = abs_state;
      default:              next_abs_state = scid_pkg::ABS_IDLE;
    endcase
    if (!sensor_ok) next_abs_state = scid_pkg::ABS_IDLE;
  end

  wire burst_fire = (abs_state == scid_pkg::ABS_BURST) && (burst_left != 16'h0000) &&
                    (burst_gap == scid_pkg::BURST_GAP_CYC);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      abs_state        <= scid_pkg::ABS_IDLE;
      sensor_ok_d      <= 1'b0;
      abs_serial_start <= 1'b0;
      abs_inc_pulse    <= 1'b0;
      burst_left       <= 16'h0000;
      burst_gap        <= 4'h0;
    end else if (clk_en) begin
      abs_state        <= next_abs_state;
      sensor_ok_d      <= sensor_ok;
      abs_serial_start <= (abs_state == scid_pkg::ABS_IDLE) && (next_abs_state == scid_pkg::ABS_SERIAL);
      abs_inc_pulse    <= burst_fire;
      if (abs_state == scid_pkg::ABS_SERIAL) begin
        burst_left <= single_turn_pos;
        burst_gap  <= 4'h0;
      end else if (burst_fire) begin
        burst_left <= burst_left - 16'h0001;
        burst_gap  <= 4'h0;
      end else if (burst_gap != scid_pkg::BURST_GAP_CYC) begin
        burst_gap <= burst_gap + 4'h1;
      end
    end
  end

  // drive enable and overtravel handling
  wire abs_ready  = !cfg.absolute_iface_select ||
                    (sensor_ok && encoder_ready && (abs_state == scid_pkg::ABS_DONE));
  wire ot_stop_md = (cfg.drive_prohibit_select == 2'h1);
  wire ot_alm_md  = (cfg.drive_prohibit_select == 2'h2);
  wire alarm_set  = ot_alm_md && (fwd_ot || rev_ot);
  wire alarm_clr  = reg_wr && (reg_addr == scid_pkg::ADDR_STATUS) && reg_wdata[scid_pkg::STAT_ALARM_BIT];
  wire rate_clr   = reg_wr && (reg_addr == scid_pkg::ADDR_STATUS) && reg_wdata[scid_pkg::STAT_RATE_BIT];
  wire next_drive = run_assigned && run_active && abs_ready &&
                    !overtravel_protection_alarm;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      drive_enable                <= 1'b0;
      fwd_stop_request            <= 1'b0;
      rev_stop_request            <= 1'b0;
      stop_action                 <= 2'h0;
      overtravel_protection_alarm <= 1'b0;
      rate_error                  <= 1'b0;
    end else if (clk_en) begin
      drive_enable     <= next_drive;
      fwd_stop_request <= ot_stop_md && fwd_ot;
      rev_stop_request <= ot_stop_md && rev_ot;
      stop_action      <= cfg.overtravel_stop_select;
      // a set in the clearing cycle wins
      overtravel_protection_alarm <= alarm_set || (overtravel_protection_alarm && !alarm_clr);
      rate_error                  <= too_fast || (rate_error && !rate_clr);
    end
  end

  // analog routing
  function automatic logic signed [15:0] scale_it(input logic signed [11:0] a, input logic [15:0] s);
    logic signed [28:0] p;
    p = a * $signed({1'b0, s});
    return p[23:8];
  endfunction

  wire torque_md = (control_mode == scid_pkg::MODE_TORQUE);
  wire speed_md  = (control_mode == scid_pkg::MODE_SPEED);
  wire tcs_one   = (cfg.torque_cmd_speed_limit_select == 2'h1);
  wire tls_sep   = (cfg.torque_limit_select == 3'h0) || (cfg.torque_limit_select == 3'h4);
  wire tls_both  = (cfg.torque_limit_select == 3'h5);
  scid_pkg::scid_analog_s next_route;
  always_comb begin
    next_route                   = '0;
    next_route.speed_cmd_valid   = speed_md;
    next_route.speed_cmd         = scale_it(analog_in1, speed_cmd_scale);
    next_route.speed_limit_valid = torque_md && tcs_one;
    next_route.speed_limit       = scale_it(analog_in1, speed_cmd_scale);
    next_route.torque_cmd_valid  = torque_md;
    next_route.torque_cmd        = tcs_one ? scale_it(analog_in2, torque_cmd_scale)
                                           : scale_it(analog_in1, torque_cmd_scale);
    next_route.fwd_limit_valid   = !torque_md && (tls_sep || tls_both);
    next_route.fwd_limit         = scale_it(analog_in2, analog_torque_limit_scale);
    next_route.rev_limit_valid   = !torque_md && (tls_sep || tls_both);
    next_route.rev_limit         = tls_both ? scale_it(analog_in2, analog_torque_limit_scale)
                                            : scale_it(analog_in3, analog_torque_limit_scale);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) analog_route <= '0;
    else if (clk_en) analog_route <= next_route;
  end

  // register port
  wire [31:0] status_word = {23'h0, rev_stop_request, fwd_stop_request, (abs_state != scid_pkg::ABS_IDLE),
                             enc_present, rate_error, overtravel_protection_alarm, run_active,
                             sensor_ok, drive_enable};
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      scid_pkg::ADDR_CONFIG:    rd_mux = {17'h0, cfg};
      scid_pkg::ADDR_SPD_SCALE: rd_mux = {16'h0, speed_cmd_scale};
      scid_pkg::ADDR_TRQ_SCALE: rd_mux = {16'h0, torque_cmd_scale};
      scid_pkg::ADDR_TLM_SCALE: rd_mux = {16'h0, analog_torque_limit_scale};
      scid_pkg::ADDR_ASSIGN_LO: rd_mux = {2'h0, assign_lo};
      scid_pkg::ADDR_ASSIGN_HI: rd_mux = {12'h0, assign_hi};
      scid_pkg::ADDR_STATUS:    rd_mux = status_word;
      scid_pkg::ADDR_POSITION:  rd_mux = position;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg                       <= scid_pkg::RST_CONFIG[14:0];
      speed_cmd_scale           <= scid_pkg::RST_SCALE;
      torque_cmd_scale          <= scid_pkg::RST_SCALE;
      analog_torque_limit_scale <= scid_pkg::RST_SCALE;
      assign_lo                 <= scid_pkg::RST_ASSIGN_LO;
      assign_hi                 <= scid_pkg::RST_ASSIGN_HI;
      reg_rdata                 <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      if (reg_wr) begin
        case (reg_addr)
          scid_pkg::ADDR_CONFIG:    cfg                       <= reg_wdata[14:0];
          scid_pkg::ADDR_SPD_SCALE: speed_cmd_scale           <= reg_wdata[15:0];
          scid_pkg::ADDR_TRQ_SCALE: torque_cmd_scale          <= reg_wdata[15:0];
          scid_pkg::ADDR_TLM_SCALE: analog_torque_limit_scale <= reg_wdata[15:0];
          scid_pkg::ADDR_ASSIGN_LO: assign_lo                 <= reg_wdata[29:0];
          scid_pkg::ADDR_ASSIGN_HI: assign_hi                 <= reg_wdata[19:0];
          default: ;
        endcase
      end
    end
  end

  // checks
  a_run_needs_sensor: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drive_enable && $past(cfg.absolute_iface_select) |-> $past(sensor_ok) && $past(encoder_ready))
    else $error("drive enabled without sensor-on and encoder ready");
  a_unassigned_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !run_assigned |=> !drive_enable)
    else $error("drive enabled with run unassigned");
  a_drive_needs_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(drive_enable) |-> $past(run_active))
    else $error("drive enabled without run command");
  a_alarm_on_ot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ot_alm_md && (fwd_ot || rev_ot) |=> overtravel_protection_alarm ##1 !drive_enable)
    else $error("overtravel did not raise alarm");
  a_ot_default_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && (cfg.drive_prohibit_select == 2'h0) && !alarm_set && !overtravel_protection_alarm
    |=> !fwd_stop_request && !rev_stop_request && !overtravel_protection_alarm)
    else $error("overtravel acted in default setting");
  a_stop_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && ot_stop_md && fwd_ot |=> fwd_stop_request && (stop_action == $past(cfg.overtravel_stop_select)))
    else $error("overtravel stop not requested");
  a_sensor_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.absolute_iface_select |-> !sensor_ok)
    else $error("sensor-on honoured while absolute interface off");
  a_enc_absent_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
    enc_captured && !enc_present |-> (abs_state == scid_pkg::ABS_IDLE) && !abs_serial_start)
    else $error("sensor-on acted with encoder absent");
  a_dir_invert: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && step_ok |=> cmd_step && (cmd_forward == ($past(raw_fwd) ^ $past(cfg.pulse_direction_invert))))
    else $error("decoded direction wrong");
  a_serial_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    abs_inc_pulse |-> $past(abs_state) == scid_pkg::ABS_BURST)
    else $error("incremental burst outside burst phase");
  a_speed_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && speed_md |=> analog_route.speed_cmd_valid && !analog_route.torque_cmd_valid)
    else $error("speed command not routed");
endmodule : scid_top

//--- testbench/scid_host_model.sv
// host controller model that drives one pair of command pulse pins
`timescale 1ns/100ps
module scid_host_model (
  input  wire logic clk_sys,
  output logic      pin_a,
  output logic      pin_b
);
  logic [1:0] q = 2'h0;
  initial pin_a = 1'b0;
  initial pin_b = 1'b0;
  task automatic send(input logic [1:0] m, input logic fwd, input int gap);
    @(posedge clk_sys);
    if (m == 2'h1) begin // a rises for reverse, b for forward
      pin_a <= !fwd;
      pin_b <= fwd;
    end else if (m == 2'h3) begin // direction level first, then the feed edge
      pin_b <= fwd;
      repeat (gap) @(posedge clk_sys);
      pin_a <= 1'b1;
    end else begin // one gray step, a leads b going forward
      q = fwd ? q + 2'h1 : q - 2'h1;
      pin_a <= q == 2'h1 || q == 2'h2;
      pin_b <= q[1];
    end
    repeat (gap) @(posedge clk_sys);
    if (m[0]) begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (gap) @(posedge clk_sys);
    end
  endtask : send
endmodule : scid_host_model

//--- testbench/servo_command_input_decoder_test.sv
// self-checking bench of the servo command input decoder
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("wrong value t=%0t %0h %0h", $time, g, e); end end
module servo_command_input_decoder_test;
  logic clk_sys, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sensor_on_input = 1'b0, f, enc_conn = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic lr_phase_a, lr_phase_b, pc_led_a, pc_led_b, cmd_step, cmd_forward, drive_enable, abs_inc_pulse;
  logic fwd_stop_request, rev_stop_request, overtravel_protection_alarm;
  logic [1:0] stop_action, control_mode = 2'h0, mt[4] = '{2'h1, 2'h3, 2'h0, 2'h2};
  logic [9:0] seq_terminal = 10'h000;
  logic signed [11:0] analog_in1 = 12'h000, analog_in2 = 12'h000, analog_in3 = 12'h000;
  scid_pkg::scid_analog_s analog_route;
  integer n_fail = 0, compares = 0, n_inc = 0, seed = 32'h5FB2;
  logic q_exp[$];
  scid_top u_scid_top (.clk_sys, .rst_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .lr_phase_a, .lr_phase_b, .pc_led_a, .pc_led_b, .seq_terminal, .sensor_on_input, .encoder_connected(enc_conn),
    .encoder_ready(1'b1), .abs_serial_done(1'b1), .single_turn_pos(16'h0003), .control_mode, .analog_in1,
    .analog_in2, .analog_in3, .cmd_step, .cmd_forward, .drive_enable, .abs_serial_start(), .abs_inc_pulse,
    .fwd_stop_request, .rev_stop_request, .stop_action, .overtravel_protection_alarm, .analog_route);
  scid_host_model u_lr (.clk_sys, .pin_a(lr_phase_a), .pin_b(lr_phase_b));
  scid_host_model u_pc (.clk_sys, .pin_a(pc_led_a), .pin_b(pc_led_b));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (cmd_step === 1'b1) begin
      if (q_exp.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(cmd_forward, q_exp.pop_front())
    end
    if (abs_inc_pulse === 1'b1) n_inc++;
  end
  task automatic wrap_up;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : hold
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys) reg_wr <= 1'b0;
    hold(6);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    @(negedge clk_sys) rv = reg_rdata;
  endtask : rd
  // both paths see the same pulses, only the selected one may count
  task automatic burst(input logic [1:0] m, input logic inv, input logic path);
    wr(scid_pkg::ADDR_CONFIG, {28'h0, m, inv, path});
    for (int i = 0; i < 4; i++) begin
      f = 1'($random(seed));
      q_exp.push_back(f ^ inv);
      if (path) u_lr.send(m, f, 3);
      else u_pc.send(m, f, 25);
      if (path) u_pc.send(m, f, 3);
      else u_lr.send(m, f, 3);
    end
    hold(6);
    `CHK(q_exp.size(), 0)
  endtask : burst
  task automatic ana(input logic [31:0] c, input logic [1:0] m);
    wr(scid_pkg::ADDR_CONFIG, c);
    @(posedge clk_sys) control_mode <= m;
    hold(3);
  endtask : ana
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(scid_pkg::ADDR_ASSIGN_LO);
    `CHK(rv, 32'h0200_0043)
    rd(8'h40);
    `CHK(rv, 32'h0000_0000)
    foreach (mt[i]) for (int v = 0; v < 4; v++) burst(mt[i], v[1], v[0]);
    rd(scid_pkg::ADDR_STATUS);
    `CHK(rv[4], 1'b0)
    @(posedge clk_sys) seq_terminal <= 10'h020;
    hold(6);
    `CHK(drive_enable, 1'b1)
    wr(scid_pkg::ADDR_ASSIGN_LO, 32'h2200_0043);
    `CHK(drive_enable, 1'b0)
    wr(scid_pkg::ADDR_ASSIGN_LO, 32'h0000_0043);
    `CHK(drive_enable, 1'b0)
    wr(scid_pkg::ADDR_ASSIGN_LO, 32'h0200_0043);
    @(posedge clk_sys) seq_terminal <= 10'h022;
    hold(6);
    `CHK({drive_enable, fwd_stop_request}, 2'h2)
    wr(scid_pkg::ADDR_CONFIG, 32'h120);
    `CHK({fwd_stop_request, rev_stop_request, stop_action}, 4'hA)
    wr(scid_pkg::ADDR_CONFIG, 32'h40);
    `CHK({overtravel_protection_alarm, drive_enable}, 2'h2)
    @(posedge clk_sys) seq_terminal <= 10'h020;
    wr(scid_pkg::ADDR_CONFIG, 32'h10);
    wr(scid_pkg::ADDR_STATUS, 32'h8);
    `CHK({overtravel_protection_alarm, drive_enable}, 2'h0)
    @(posedge clk_sys) sensor_on_input <= 1'b1;
    hold(60);
    `CHK(n_inc, 3)
    `CHK(drive_enable, 1'b1)
    @(posedge clk_sys) begin
      analog_in1 <= 12'($random(seed));
      analog_in2 <= 12'($random(seed));
      analog_in3 <= 12'($random(seed));
    end
    ana(32'h0, scid_pkg::MODE_SPEED);
    `CHK(analog_route.speed_cmd, 16'(analog_in1))
    ana(32'h200, scid_pkg::MODE_TORQUE);
    `CHK(analog_route.speed_limit, 16'(analog_in1))
    `CHK(analog_route.torque_cmd, 16'(analog_in2))
    ana(32'h2800, scid_pkg::MODE_POS);
    `CHK({analog_route.fwd_limit, analog_route.rev_limit}, {16'(analog_in2), 16'(analog_in2)})
    ana(32'h2000, scid_pkg::MODE_POS);
    `CHK(analog_route.rev_limit, 16'(analog_in3))
    // second power-up with the encoder unplugged: sensor-on must be ignored
    @(posedge clk_sys) begin
      rst_n <= 1'b0;
      enc_conn <= 1'b0;
    end
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(scid_pkg::ADDR_CONFIG, 32'h10);
    hold(20);
    `CHK(drive_enable, 1'b0)
    `CHK(n_inc, 3)
    rd(scid_pkg::ADDR_STATUS);
    `CHK(rv[6:0], 7'h04)
    wrap_up();
  end
endmodule : servo_command_input_decoder_test
